// File: cgu_map.vh
// register map, field positions, reset values and counts of the clock unit
// assumes 12-bit byte addressing on the register bus, 32-bit data words
`ifndef CLK_GEN_MAP_VH
`define CLK_GEN_MAP_VH
`define OFS_PLL_CTRL   12'h044
`define OFS_SYS_SEL    12'h050
`define OFS_CLK_STAT   12'h054
`define OFS_OSC_CTRL   12'h0B0
// pll control register fields
`define PC_BYP         0
`define PC_DISC        1
`define PC_N_LO        2
`define PC_N_HI        5
`define PC_K2_LO       6
`define PC_K2_HI       7
`define PC_K1          8
`define PC_P_LO        9
`define PC_P_HI        10
`define PC_LOCK        11
`define PC_RST_BYP     1'h1
`define PC_RST_DISC    1'h0
`define PC_RST_N       4'h7
`define PC_RST_K2      2'h2
`define PC_RST_K1      1'h0
`define PC_RST_P       2'h1
// p divider codes
`define P_CODE4        2'h0
`define P_CODE5        2'h1
`define P_CODE6        2'h2
`define P_CODE_BAD     2'h3
`define P_DIV4         8'h04
`define P_DIV5         8'h05
`define P_DIV6         8'h06
`define N_OFFSET       8'h01
`define K2_OFFSET      8'h02
`define K1_OFFSET      8'h01
// oscillator control register fields
`define OC_RSS_LO      0
`define OC_RSS_HI      1
`define OC_TOOLOW      2
`define OC_WDTRST      3
`define RSS_INT        2'h0
`define RSS_EXT        2'h1
`define OC_RST_RSS     2'h0
// system source select
`define SRC_PLL        2'h0
`define SRC_OSC        2'h1
`define SRC_INT        2'h2
`define SRC_LP         2'h3
`define SYS_RST_SRC    2'h2
`define SS_SRC_LO      0
`define SS_SRC_HI      1
// status register fields
`define ST_MODE_LO     0
`define ST_MODE_HI     3
`define ST_LPHOLD      4
`define ST_SRC_LO      5
`define ST_SRC_HI      6
// counts
`define LP_START_TICKS 8'h10
`define WDT_LIMIT      8'h08
`define LOCK_WIN       8'h10
`define LOCK_TOL       8'h01
`endif

// File: clk_div.v
// tick divider: passes every divisor-th input tick as a one-cycle pulse
// assumes tickIn is a one-cycle enable in the clk_sys domain
`timescale 1ns/1ps
module clk_div (
  input  wire       clk_sys,
  input  wire       rstn,
  input  wire       clr,
  input  wire       tickIn,
  input  wire [7:0] divisor,
  output reg        tickOut
);
  reg [7:0] cnt_reg;
  reg [7:0] curDiv_reg;

  // a new divisor is taken at a period boundary or on clr, which restarts the count, so no short period
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_reg    <= 8'h00;
      curDiv_reg <= 8'h01;
      tickOut    <= 1'b0;
    end else if (clr) begin
      cnt_reg    <= 8'h00;
      curDiv_reg <= divisor;
      tickOut    <= 1'b0;
    end else if (tickIn) begin
      if (cnt_reg + 8'h01 >= curDiv_reg) begin
        cnt_reg    <= 8'h00;
        curDiv_reg <= divisor;
        tickOut    <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 8'h01;
        tickOut <= 1'b0;
      end
    end else begin
      tickOut <= 1'b0;
    end
  end
endmodule

// File: lock_detect.v
// lock detector: compares feedback ticks against reference ticks per window
// assumes both ticks are one-cycle enables in the clk_sys domain
`include "cgu_map.vh"
`timescale 1ns/1ps
module lock_detect (
  input  wire clk_sys,
  input  wire rstn,
  input  wire clr,
  input  wire refTick,
  input  wire fbTick,
  output reg  lock
);
  reg  [7:0] winCnt_reg;
  reg  [7:0] fbCnt_reg;
  reg        bad_reg;
  wire [7:0] fbNow;
  wire       inTol;
  wire       winEnd;

  assign fbNow  = fbCnt_reg + {7'h00, fbTick};
  assign inTol  = (fbNow + `LOCK_TOL >= `LOCK_WIN) &&
                  (fbNow <= `LOCK_WIN + `LOCK_TOL);
  assign winEnd = refTick && (winCnt_reg + 8'h01 >= `LOCK_WIN);

  // one bad window alone is forgiven: small slow drift keeps lock
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      winCnt_reg <= 8'h00;
      fbCnt_reg  <= 8'h00;
      bad_reg    <= 1'b0;
      lock       <= 1'b0;
    end else if (clr) begin
      winCnt_reg <= 8'h00;
      fbCnt_reg  <= 8'h00;
      bad_reg    <= 1'b0;
      lock       <= 1'b0;
    end else if (winEnd) begin
      winCnt_reg <= 8'h00;
      fbCnt_reg  <= 8'h00;
      bad_reg    <= ~inTol;
      if (inTol)
        lock <= 1'b1;
      else if (bad_reg)
        lock <= 1'b0;
    end else begin
      if (refTick)
        winCnt_reg <= winCnt_reg + 8'h01;
      if (fbTick && fbCnt_reg != 8'hFF)
        fbCnt_reg <= fbNow;
    end
  end
endmodule

// File: pll_clock_generation.v
// clock generation unit: pll mode control, dividers, source selection
// assumes all clocks arrive as one-cycle ticks synchronous to clk_sys
// Operation
// - system clock comes from pll, oscillator, internal oscillator or lp clock.
// - lp clock is forced by hardware after reset and wake-up, not configurable.
// - pll reference is the internal oscillator or the external oscillator.
// - bypass selects prescaler; else disconnect selects freerun, else normal.
// - prescaler skips p, n, k2; normal skips k1; freerun skips k1, ignores p.
// - normal output is reference times n over p times k2.
// - normal mode only with bypass 0, disconnect 0 and lock 1.
// - prescaler output is reference divided by k1 only.
// - prescaler with bypass 1; external reference also needs too-low 0.
// - freerun output is vco base rate divided by k2 only.
// - freerun on lost lock, too-low external in bypass, or disconnect.
// - p divider takes only the factors four, five and six.
// - n field is 4 bits, k2 field 2 bits, k1 field 1 bit.
// - switching k dividers or normal and prescaler gives no runt pulse.
// - pll sleeps by itself whenever the device is in power save.
// - internal oscillator serves as pll input after reset; rss can select the external one.
// - lock is lost on two mismatched windows in a row, or on bypass, disconnect or power save.
`include "cgu_map.vh"
`timescale 1ns/1ps
module pll_clock_generation (
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        oscTick,
  input  wire        intOscTick,
  input  wire        lpTick,
  input  wire        vcoTick,
  input  wire        powerSave,
  output reg         sysClkTick,
  output reg         pllTick,
  output reg         vcoRefTick,
  output reg         pllSleep
);
  localparam [3:0] MODE_PRE   = 4'b0001;
  localparam [3:0] MODE_NORM  = 4'b0010;
  localparam [3:0] MODE_FREE  = 4'b0100;
  localparam [3:0] MODE_SLEEP = 4'b1000;

  reg        bypass_reg;
  reg        disc_reg;
  reg  [3:0] nField_reg;
  reg  [1:0] k2Field_reg;
  reg        k1Field_reg;
  reg  [1:0] pCode_reg;
  reg  [1:0] rss_reg;
  reg  [1:0] sysSel_reg;
  reg  [3:0] mode_reg;
  reg  [3:0] mode_next;
  reg  [1:0] src_reg;
  reg        lpHold_reg;
  reg  [7:0] lpCnt_reg;
  reg        psPrev_reg;
  reg  [7:0] wdCnt_reg;
  reg        tooLow_reg;
  reg  [7:0] pDivisor;
  reg  [31:0] rdData;
  reg        mapped;
  reg        curTick;
  reg        pllRaw;

  wire       lock;
  wire       refTick;
  wire       refDivTick;
  wire       fbTick;
  wire       k1Tick;
  wire       k2Tick;
  wire       extRef;
  wire       accessPh;
  wire       wrEn;
  wire       wrPll;
  wire       wrOsc;
  wire       wrSel;
  wire       wdRestart;
  wire       modeSwitch;
  wire       clrK1;
  wire       clrK2;
  wire       lockClr;
  wire       wake;
  wire [1:0] srcWant;
  wire       srcSwitch;
  wire [7:0] nDivisor;
  wire [7:0] k2Divisor;
  wire [7:0] k1Divisor;

  // register bus: one wait state, write lands on the edge with pready high
  assign accessPh = psel & penable;
  assign wrEn     = accessPh & pready & pwrite & mapped;
  assign wrPll    = wrEn & (paddr == `OFS_PLL_CTRL);
  assign wrOsc    = wrEn & (paddr == `OFS_OSC_CTRL);
  assign wrSel    = wrEn & (paddr == `OFS_SYS_SEL);
  assign wdRestart = wrOsc & pwdata[`OC_WDTRST];

  always @* begin
    rdData = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      `OFS_PLL_CTRL: begin
        rdData[`PC_BYP]              = bypass_reg;
        rdData[`PC_DISC]             = disc_reg;
        rdData[`PC_N_HI:`PC_N_LO]    = nField_reg;
        rdData[`PC_K2_HI:`PC_K2_LO]  = k2Field_reg;
        rdData[`PC_K1]               = k1Field_reg;
        rdData[`PC_P_HI:`PC_P_LO]    = pCode_reg;
        rdData[`PC_LOCK]             = lock;
      end
      `OFS_OSC_CTRL: begin
        rdData[`OC_RSS_HI:`OC_RSS_LO] = rss_reg;
        rdData[`OC_TOOLOW]            = tooLow_reg;
      end
      `OFS_SYS_SEL: begin
        rdData[`SS_SRC_HI:`SS_SRC_LO] = sysSel_reg;
      end
      `OFS_CLK_STAT: begin
        rdData[`ST_MODE_HI:`ST_MODE_LO] = mode_reg;
        rdData[`ST_LPHOLD]              = lpHold_reg;
        rdData[`ST_SRC_HI:`ST_SRC_LO]   = src_reg;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= accessPh & ~pready;
      pslverr <= accessPh & ~pready & ~mapped;
      if (accessPh & ~pready)
        prdata <= pwrite ? 32'h0000_0000 : rdData;
    end
  end

  // software-visible control; lock and too-low have no write path
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bypass_reg  <= `PC_RST_BYP;
      disc_reg    <= `PC_RST_DISC;
      nField_reg  <= `PC_RST_N;
      k2Field_reg <= `PC_RST_K2;
      k1Field_reg <= `PC_RST_K1;
      pCode_reg   <= `PC_RST_P;
      rss_reg     <= `OC_RST_RSS;
      sysSel_reg  <= `SYS_RST_SRC;
    end else begin
      if (wrPll) begin
        bypass_reg  <= pwdata[`PC_BYP];
        disc_reg    <= pwdata[`PC_DISC];
        nField_reg  <= pwdata[`PC_N_HI:`PC_N_LO];
        k2Field_reg <= pwdata[`PC_K2_HI:`PC_K2_LO];
        k1Field_reg <= pwdata[`PC_K1];
        // the unused p code is dropped, the old factor stays
        if (pwdata[`PC_P_HI:`PC_P_LO] != `P_CODE_BAD)
          pCode_reg <= pwdata[`PC_P_HI:`PC_P_LO];
      end
      // only internal or external reference codes are accepted
      if (wrOsc && !pwdata[`OC_RSS_HI])
        rss_reg <= pwdata[`OC_RSS_HI:`OC_RSS_LO];
      if (wrSel)
        sysSel_reg <= pwdata[`SS_SRC_HI:`SS_SRC_LO];
    end
  end

  // reference path and divisor decode
  assign extRef  = (rss_reg == `RSS_EXT);
  assign refTick = extRef ? oscTick : intOscTick;

  always @* begin
    case (pCode_reg)
      `P_CODE4: pDivisor = `P_DIV4;
      `P_CODE5: pDivisor = `P_DIV5;
      `P_CODE6: pDivisor = `P_DIV6;
      default:  pDivisor = `P_DIV5;
    endcase
  end

  assign nDivisor  = {4'h0, nField_reg} + `N_OFFSET;
  assign k2Divisor = {6'h00, k2Field_reg} + `K2_OFFSET;
  assign k1Divisor = {7'h00, k1Field_reg} + `K1_OFFSET;

  // oscillator watchdog: internal ticks counted between external ticks
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wdCnt_reg  <= 8'h00;
      tooLow_reg <= 1'b0;
    end else if (wdRestart) begin
      wdCnt_reg  <= 8'h00;
      // a limit reached in this very cycle wins over the restart
      tooLow_reg <= (wdCnt_reg >= `WDT_LIMIT) && !tooLow_reg;
    end else if (oscTick) begin
      wdCnt_reg  <= 8'h00;
      tooLow_reg <= (wdCnt_reg >= `WDT_LIMIT);
    end else if (intOscTick && wdCnt_reg < `WDT_LIMIT) begin
      wdCnt_reg <= wdCnt_reg + 8'h01;
    end else if (wdCnt_reg >= `WDT_LIMIT) begin
      tooLow_reg <= 1'b1;
    end
  end

  // mode decode from power save, bypass, disconnect, lock and too-low
  always @* begin
    if (powerSave)
      mode_next = MODE_SLEEP;
    else if (bypass_reg)
      mode_next = (extRef && tooLow_reg) ? MODE_FREE
                                         : MODE_PRE;
    else if (!disc_reg && lock)
      mode_next = MODE_NORM;
    else
      mode_next = MODE_FREE;
  end

  // mode changes at an output period boundary, or at once into or out of sleep, so no runt
  // a dead external reference gives no boundary, its output is idle
  assign modeSwitch = (mode_reg != mode_next) &&
                      (pllRaw || mode_reg == MODE_SLEEP ||
                       mode_next == MODE_SLEEP ||
                       (mode_reg == MODE_PRE && extRef && tooLow_reg));
  assign clrK1   = modeSwitch && (mode_next == MODE_PRE);
  assign clrK2   = modeSwitch && (mode_reg == MODE_PRE ||
                                  mode_reg == MODE_SLEEP);
  assign lockClr = bypass_reg | disc_reg | powerSave;

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      mode_reg <= MODE_PRE;
    else if (modeSwitch)
      mode_reg <= mode_next;
  end

  always @* begin
    case (mode_reg)
      MODE_PRE:   pllRaw = k1Tick;
      MODE_NORM:  pllRaw = k2Tick;
      MODE_FREE:  pllRaw = k2Tick;
      MODE_SLEEP: pllRaw = 1'b0;
      default:    pllRaw = 1'b0;
    endcase
  end

  clk_div u_pDiv (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .clr     (1'b0),
    .tickIn  (refTick),
    .divisor (pDivisor),
    .tickOut (refDivTick)
  );

  clk_div u_feedback_divider_field (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .clr     (lockClr),
    .tickIn  (vcoTick),
    .divisor (nDivisor),
    .tickOut (fbTick)
  );

  clk_div u_output_divider_field (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .clr     (clrK2),
    .tickIn  (vcoTick),
    .divisor (k2Divisor),
    .tickOut (k2Tick)
  );

  clk_div u_prescale_divider_field (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .clr     (clrK1),
    .tickIn  (refTick),
    .divisor (k1Divisor),
    .tickOut (k1Tick)
  );

  lock_detect u_lock (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .clr     (lockClr),
    .refTick (refDivTick),
    .fbTick  (fbTick),
    .lock    (lock)
  );

  // pll-facing outputs; disconnect cuts the reference to the vco
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pllTick    <= 1'b0;
      vcoRefTick <= 1'b0;
      pllSleep   <= 1'b0;
    end else begin
      pllTick    <= pllRaw;
      vcoRefTick <= refDivTick & ~disc_reg & ~powerSave;
      pllSleep   <= powerSave;
    end
  end

  // lp clock hold after reset and across wake-up, no software say
  assign wake = psPrev_reg & ~powerSave;

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lpHold_reg <= 1'b1;
      lpCnt_reg  <= 8'h00;
      psPrev_reg <= 1'b0;
    end else begin
      psPrev_reg <= powerSave;
      if (powerSave || wake) begin
        lpHold_reg <= 1'b1;
        lpCnt_reg  <= 8'h00;
      end else if (lpHold_reg && lpTick) begin
        if (lpCnt_reg + 8'h01 >= `LP_START_TICKS)
          lpHold_reg <= 1'b0;
        lpCnt_reg <= lpCnt_reg + 8'h01;
      end
    end
  end

  // source mux; a dead external oscillator may be left without a boundary
  assign srcWant   = lpHold_reg ? `SRC_LP : sysSel_reg;
  assign srcSwitch = (src_reg != srcWant) &&
                     (curTick || (src_reg == `SRC_OSC && tooLow_reg));

  always @* begin
    case (src_reg)
      `SRC_PLL: curTick = pllRaw;
      `SRC_OSC: curTick = oscTick;
      `SRC_INT: curTick = intOscTick;
      `SRC_LP:  curTick = lpTick;
      default:  curTick = lpTick;
    endcase
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      src_reg    <= `SRC_LP;
      sysClkTick <= 1'b0;
    end else begin
      if (srcSwitch)
        src_reg <= srcWant;
      sysClkTick <= curTick;
    end
  end
endmodule

// File: osc_source_model.sv
// external clock source on the crystal input, as one-cycle ticks
// assumes clk_sys timing; stands still while run is low
`timescale 1ns/1ps
module osc_source_model (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       run,
  input  wire logic [7:0] period,
  output logic            oscTick
);
  logic [7:0] count;
  wire        last = (count == period - 8'h01);
  // bench keeps period at 4 MHz or more, inside the vco range
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn || !run) begin
      count   <= 8'h00;
      oscTick <= 1'b0;
    end else begin
      oscTick <= last;
      count   <= last ? 8'h00 : count + 8'h01;
    end
  end
endmodule

// File: pll_clock_generation_props.sv
// port checker for the clock generation unit
// assumes one clk_sys domain and asynchronous active-low rstn
`timescale 1ns/1ps
module pll_clock_generation_props (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        oscTick,
  input wire logic        intOscTick,
  input wire logic        lpTick,
  input wire logic        vcoTick,
  input wire logic        powerSave,
  input wire logic        sysClkTick,
  input wire logic        pllTick,
  input wire logic        vcoRefTick,
  input wire logic        pllSleep
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire anyIn = oscTick || intOscTick || vcoTick;
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  access_answer_a: assert property (
    psel && !penable ##1 psel && penable |=> pready)
    else $error("ready missing after access");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  sleep_follows_a: assert property (pllSleep == $past(powerSave))
    else $error("sleep not following power save");
  ref_quiet_a: assert property (powerSave[*2] |-> !vcoRefTick)
    else $error("reference fed during power save");
  sys_tick_cause_a: assert property (sysClkTick |-> pllTick ||
    $past(pllTick) || $past(anyIn || lpTick))
    else $error("system tick without source tick");
  pll_no_runt_a: assert property (pllTick |=> !pllTick)
    else $error("runt pll pulse");
  pll_tick_cause_a: assert property (
    pllTick |-> $past(anyIn) || $past(anyIn, 2))
    else $error("pll tick without input tick");
  cover property (pready && pslverr);
  cover property (pllSleep ##1 !pllSleep);
  cover property (vcoRefTick ##[1:40] pllTick);
endmodule
bind pll_clock_generation pll_clock_generation_props
  pll_clock_generation_props_inst (.clk_sys, .rstn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .oscTick,
  .intOscTick, .lpTick, .vcoTick, .powerSave, .sysClkTick, .pllTick,
  .vcoRefTick, .pllSleep);

// File: tb_top.sv
// self-checking bench for the clock generation unit over apb
// assumes the register map header is on the include path
`include "cgu_map.vh"
`timescale 1ns/1ps
module tb_top;
  logic        clk_sys;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        oscTick;
  logic        powerSave;
  logic        oscRun;
  logic [7:0]  oscPeriod;
  logic        sysClkTick;
  logic        pllTick;
  logic        vcoRefTick;
  logic        pllSleep;
  logic [7:0]  phase = 8'h00;
  logic [31:0] rdata;
  logic        rerr;
  int          miscompares;
  int          samples_checked;
  int          pllCnt;
  int          refCnt;
  int          sysCnt;
  int          mark;
  wire intOscTick = phase[0];
  wire vcoTick    = phase[0];
  wire lpTick     = (phase[1:0] == 2'h3);
  pll_clock_generation pll_clock_generation_inst (.clk_sys, .rstn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .oscTick, .intOscTick, .lpTick, .vcoTick, .powerSave, .sysClkTick,
    .pllTick, .vcoRefTick, .pllSleep);
  osc_source_model osc_source_model_inst (.clk_sys, .rstn, .run(oscRun),
    .period(oscPeriod), .oscTick);
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    phase  <= phase + 8'h01;
    pllCnt <= pllCnt + int'(pllTick);
    refCnt <= refCnt + int'(vcoRefTick);
    sysCnt <= sysCnt + int'(sysClkTick);
  end
  task automatic test_done;
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // apb transfer; holds the request until pready is seen at an edge
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rdata = prdata;
    rerr  = pslverr;
    if (n >= 40) begin
      miscompares++;
      $display("wrong value at %0t: no bus answer", $time);
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdata & m, e);
  endtask
  // mode and source change on a path tick, or at once for sleep or a dead oscillator, so poll a bounded time
  task automatic poll(input logic [11:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    for (int i = 0; i < 150; i++) begin
      xfer(1'b0, a, 32'h0);
      if ((rdata & m) === e)
        break;
    end
    chk(rdata & m, e);
  endtask
  // pll or system ticks over 400 cycles, one either way for phase
  task automatic span(input int e, input bit sys = 1'b0);
    int a;
    a = sys ? sysCnt : pllCnt;
    repeat (400) @(posedge clk_sys);
    a = (sys ? sysCnt : pllCnt) - a;
    chk({31'h0, a >= e - 1 && a <= e + 1}, 32'h1);
  endtask
  initial begin
    repeat (30000) @(posedge clk_sys);
    miscompares++;
    test_done;
  end
  initial begin
    {rstn, psel, penable, pwrite, powerSave} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    {miscompares, samples_checked, pllCnt, refCnt, sysCnt} = '0;
    oscRun = 1'b1;
    oscPeriod = 8'h02;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rd(`OFS_CLK_STAT, 32'h7F, 32'h71);
    rd(`OFS_PLL_CTRL, 32'hFFF, 32'h29D);
    xfer(1'b0, 12'h0FC, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    poll(`OFS_CLK_STAT, 32'h70, 32'h40);
    for (int s = 0; s < 4; s++) begin
      xfer(1'b1, `OFS_SYS_SEL, 32'(s));
      poll(`OFS_CLK_STAT, 32'h60, 32'(s) << 5);
    end
    xfer(1'b1, `OFS_SYS_SEL, 32'h2);
    xfer(1'b1, `OFS_PLL_CTRL, 32'hA9D);
    rd(`OFS_PLL_CTRL, 32'hFFF, 32'h29D);
    xfer(1'b1, `OFS_PLL_CTRL, 32'h69D);
    rd(`OFS_PLL_CTRL, 32'h7FF, 32'h29D);
    for (int p = 2; p >= 0; p--) begin
      xfer(1'b1, `OFS_PLL_CTRL, 32'h09D | (32'(p) << 9));
      rd(`OFS_PLL_CTRL, 32'h7FF, 32'h09D | (32'(p) << 9));
    end
    span(200);
    xfer(1'b1, `OFS_PLL_CTRL, 32'h19D);
    span(100);
    xfer(1'b1, `OFS_PLL_CTRL, 32'h18D);
    xfer(1'b1, `OFS_PLL_CTRL, 32'h18C);
    poll(`OFS_CLK_STAT, 32'hF, 32'h2);
    rd(`OFS_PLL_CTRL, 32'h800, 32'h800);
    span(50);
    xfer(1'b1, `OFS_PLL_CTRL, 32'h18E);
    poll(`OFS_CLK_STAT, 32'hF, 32'h4);
    mark = refCnt;
    repeat (100) @(posedge clk_sys);
    chk(32'(refCnt - mark), 32'h0);
    span(50);
    xfer(1'b1, `OFS_PLL_CTRL, 32'h1CE);
    span(40);
    xfer(1'b1, `OFS_PLL_CTRL, 32'h1CC);
    poll(`OFS_CLK_STAT, 32'hF, 32'h2);
    span(40);
    xfer(1'b1, `OFS_PLL_CTRL, 32'h1CD);
    poll(`OFS_CLK_STAT, 32'hF, 32'h1);
    oscPeriod <= 8'h04;
    xfer(1'b1, `OFS_OSC_CTRL, 32'h1);
    rd(`OFS_OSC_CTRL, 32'h7, 32'h1);
    span(50);
    oscRun <= 1'b0;
    poll(`OFS_CLK_STAT, 32'hF, 32'h4);
    rd(`OFS_OSC_CTRL, 32'h4, 32'h4);
    xfer(1'b1, `OFS_OSC_CTRL, 32'h9);
    rd(`OFS_OSC_CTRL, 32'h4, 32'h0);
    poll(`OFS_CLK_STAT, 32'hF, 32'h4);
    oscRun <= 1'b1;
    poll(`OFS_CLK_STAT, 32'hF, 32'h1);
    xfer(1'b1, `OFS_OSC_CTRL, 32'h0);
    span(100);
    powerSave <= 1'b1;
    poll(`OFS_CLK_STAT, 32'h1F, 32'h18);
    chk({31'h0, pllSleep}, 32'h1);
    powerSave <= 1'b0;
    rd(`OFS_CLK_STAT, 32'h10, 32'h10);
    chk({31'h0, pllSleep}, 32'h0);
    poll(`OFS_CLK_STAT, 32'h70, 32'h40);
    span(200, 1'b1);
    test_done;
  end
endmodule
